// file: verification/imrc_bus_peer.sv
// Behavioural model of the other bus devices that feed events to the block.
`timescale 1ns/1ps
module imrc_bus_peer (
    input wire logic core_clk,
    output logic frame_active,
    output logic arb_lost,
    output logic overrun,
    output logic first_byte_valid,
    output logic [7:0] first_byte
);
    initial
    begin
        frame_active = 1'b0;
        arb_lost = 1'b0;
        overrun = 1'b0;
        first_byte_valid = 1'b0;
        first_byte = 8'h5a;
    end
    // The byte flips once released, so a late sample never matches by luck.
    task automatic pulse(input int kind, input logic [7:0] b);
        @(posedge core_clk);
        arb_lost <= kind == 0;
        overrun <= kind == 1;
        first_byte_valid <= kind == 2;
        first_byte <= b;
        @(posedge core_clk);
        arb_lost <= 1'b0;
        overrun <= 1'b0;
        first_byte_valid <= 1'b0;
        first_byte <= ~b;
        #1;
    endtask
    task automatic frame(input logic on);
        @(posedge core_clk);
        frame_active <= on;
        #1;
    endtask
endmodule // imrc_bus_peer

// file: verification/tb_top.sv
// Self-checking testbench for the mode and rate control block.
`timescale 1ns/1ps
module tb_top;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0, sync_format = 1'b0, rx_read = 1'b0;
    logic [7:0] reg_rdata, first_byte, a;
    logic irq, frame_active, arb_lost, overrun, first_byte_valid;
    logic next_rx_enable, interface_enable, bit_tick, scl_out, scl_oe;
    logic [1:0] mode_code;
    logic [3:0] active_rate_code;
    logic [7:0] exp_q[$];
    int num_errors = 0, compares = 0, gap = 0, cnt = 0, ticks = 0, t0;
    logic [31:0] seed = 32'hdf00;
    int divs[16] = '{28, 40, 48, 64, 80, 100, 112, 128, 56, 80, 96, 128, 160, 200, 224, 256};
    imrc_mode_rate_ctrl #(.DIV_CNT_W(8)) dut_u (.core_clk(core_clk), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq), .sync_format(sync_format),
        .frame_active(frame_active), .arb_lost(arb_lost), .overrun(overrun),
        .first_byte_valid(first_byte_valid), .first_byte(first_byte),
        .receive_buffer_read(rx_read), .mode_code(mode_code),
        .next_rx_enable(next_rx_enable), .interface_enable(interface_enable),
        .active_rate_code(active_rate_code), .bit_tick(bit_tick), .scl_out(scl_out),
        .scl_oe(scl_oe));
    imrc_bus_peer peer_u (.core_clk(core_clk), .frame_active(frame_active),
        .arb_lost(arb_lost), .overrun(overrun), .first_byte_valid(first_byte_valid),
        .first_byte(first_byte));
    initial
    begin
        forever #2.5 core_clk = ~core_clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
        compares++;
        if (g !== e)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [2:0] ad, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [2:0] ad, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge core_clk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
    endtask
    task automatic run_ticks(input int n);
        t0 = ticks;
        repeat (2000) if (ticks < t0 + n) @(posedge core_clk);
        #1;
    endtask
    // Read data stand only in the cycle after the strobe, so they are taken there.
    always @(posedge core_clk)
    begin
        rd_d <= reg_rd;
        cnt <= bit_tick ? 1 : cnt + 1;
        if (bit_tick)
        begin
            gap <= cnt;
            ticks <= ticks + 1;
        end
        if (rd_d && exp_q.size() > 0)
            chk("reg_rdata", 9'(exp_q.pop_front()), 9'(reg_rdata));
    end
    task automatic conclude;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        #300000;
        num_errors++;
        conclude();
    end
    initial
    begin
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        rd(3'h0, 8'h00);
        chk("interface_enable", 9'h0, 9'(interface_enable));
        chk("scl_out", 9'h0, 9'(scl_out));
        for (int m = 0; m < 4; m++)
        begin
            wr(3'h0, 8'h80 | 8'(m << 4));
            rd(3'h4, 8'(m));
            chk("mode_code", 9'(m), 9'(mode_code));
        end
        $display("test modes done");
        wr(3'h3, 8'h00);
        peer_u.pulse(0, 8'h00);
        rd(3'h4, 8'h00);
        chk("irq", 9'h0, 9'(irq));
        wr(3'h3, 8'h01);
        chk("irq", 9'h1, 9'(irq));
        wr(3'h2, 8'h01);
        chk("irq", 9'h0, 9'(irq));
        @(posedge core_clk) sync_format <= 1'b1;
        wr(3'h0, 8'hb0);
        peer_u.pulse(0, 8'h00);
        rd(3'h4, 8'h07);
        peer_u.pulse(1, 8'h00);
        rd(3'h4, 8'h04);
        rd(3'h2, 8'h02);
        $display("test mode drops done");
        @(posedge core_clk) sync_format <= 1'b0;
        seed = xs(seed);
        a = {seed[6:0], 1'b0};
        wr(3'h1, a);
        wr(3'h0, 8'h80);
        peer_u.pulse(2, a);
        peer_u.pulse(2, a ^ 8'h03);
        rd(3'h4, 8'h00);
        peer_u.pulse(2, a | 8'h01);
        rd(3'h4, 8'h01);
        rd(3'h1, a);
        rd(3'h2, 8'h06);
        wr(3'h2, 8'hff);
        $display("test address match done");
        wr(3'h0, 8'hc0);
        @(posedge core_clk) rx_read <= 1'b1;
        @(posedge core_clk) rx_read <= 1'b0;
        rd(3'h4, 8'h10);
        chk("next_rx_enable", 9'h0, 9'(next_rx_enable));
        rd(3'h2, 8'h08);
        wr(3'h0, 8'h80);
        @(posedge core_clk);
        #1;
        chk("next_rx_enable", 9'h1, 9'(next_rx_enable));
        $display("test reception hold done");
        @(posedge core_clk) sync_format <= 1'b1;
        for (int c = 0; c < 16; c++)
        begin
            wr(3'h0, 8'ha0 | 8'(c));
            run_ticks(3);
            chk("half_period", 9'(divs[c] / 2), 9'(gap));
            chk("active_rate_code", 9'(c), 9'(active_rate_code));
            chk("scl_oe", 9'h1, 9'(scl_oe));
        end
        peer_u.frame(1'b1);
        wr(3'h0, 8'ha0);
        run_ticks(2);
        chk("half_period", 9'd128, 9'(gap));
        chk("active_rate_code", 9'hf, 9'(active_rate_code));
        peer_u.frame(1'b0);
        run_ticks(3);
        chk("half_period", 9'd14, 9'(gap));
        wr(3'h0, 8'h83);
        t0 = ticks;
        repeat (300) @(posedge core_clk);
        #1;
        chk("tick_count", 9'(t0), 9'(ticks));
        chk("scl_oe", 9'h0, 9'(scl_oe));
        chk("scl_out", 9'h1, 9'(scl_out));
        chk("interface_enable", 9'h1, 9'(interface_enable));
        $display("test rates done");
        wr(3'h6, 8'hff);
        rd(3'h6, 8'h00);
        rd(3'h5, 8'h00);
        $display("test unmapped done");
        repeat (3) @(posedge core_clk);
        conclude();
    end
endmodule // tb_top

// file: verilog/imrc_mode_rate_ctrl.sv
// Mode selection and transfer rate control for the two-wire interface.
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps
module imrc_mode_rate_ctrl #(
    parameter int DIV_CNT_W = 8
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic irq,
    input wire logic sync_format,
    input wire logic frame_active,
    input wire logic arb_lost,
    input wire logic overrun,
    input wire logic first_byte_valid,
    input wire logic [7:0] first_byte,
    input wire logic receive_buffer_read,
    output logic [1:0] mode_code,
    output logic next_rx_enable,
    output logic interface_enable,
    output logic [3:0] active_rate_code,
    output logic bit_tick,
    output logic scl_out,
    output logic scl_oe
);
    logic interface_enable_q;
    logic reception_hold;
    logic master_select;
    logic transmit_select;
    logic [3:0] rate_select;
    logic [6:0] own_address_register;
    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    logic rx_stall;
    logic [7:0] rdata;

    imrc_rate_if rif ();

    imrc_rate_div #(
        .CNT_W(DIV_CNT_W)
    ) u_div (
        .core_clk(core_clk),
        .reset(reset),
        .rif(rif)
    );

    // Address decode.
    wire wr_control = reg_wr && (reg_addr == imrc_pkg::OFF_CONTROL);
    wire wr_own = reg_wr && (reg_addr == imrc_pkg::OFF_OWN_ADDR);
    wire wr_status = reg_wr && (reg_addr == imrc_pkg::OFF_IRQ_STATUS);
    wire wr_mask = reg_wr && (reg_addr == imrc_pkg::OFF_IRQ_MASK);

    // Hardware mode changes.
    wire slave_rx = !master_select && !transmit_select;
    wire ev_arb = arb_lost && master_select && !sync_format;
    wire ev_ovr = overrun && master_select && sync_format;
    wire addr_hit = first_byte[7:1] == own_address_register;
    wire ev_match = first_byte_valid && slave_rx && addr_hit && first_byte[0];
    wire ev_hold = receive_buffer_read && reception_hold && !transmit_select;
    wire drop_to_slave = ev_arb || ev_ovr;

    wire [3:0] events = {ev_hold, ev_match, ev_ovr, ev_arb};
    wire [3:0] next_irq_status = events | (irq_status & ~(wr_status ? reg_wdata[3:0] : 4'h0));

    wire next_master = drop_to_slave ? 1'b0
        : (wr_control ? reg_wdata[imrc_pkg::BIT_MASTER_SELECT] : master_select);
    wire next_transmit = drop_to_slave ? 1'b0
        : ev_match ? 1'b1
        : (wr_control ? reg_wdata[imrc_pkg::BIT_TRANSMIT_SELECT] : transmit_select);

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            interface_enable_q <= imrc_pkg::CONTROL_RESET[imrc_pkg::BIT_ENABLE];
            reception_hold <= imrc_pkg::CONTROL_RESET[imrc_pkg::BIT_RECEPTION_HOLD];
            master_select <= imrc_pkg::CONTROL_RESET[imrc_pkg::BIT_MASTER_SELECT];
            transmit_select <= imrc_pkg::CONTROL_RESET[imrc_pkg::BIT_TRANSMIT_SELECT];
            rate_select <= imrc_pkg::CONTROL_RESET[imrc_pkg::RATE_LSB +: imrc_pkg::RATE_W];
            own_address_register <= imrc_pkg::OWN_ADDR_RESET;
            irq_status <= imrc_pkg::IRQ_RESET;
            irq_mask <= imrc_pkg::IRQ_RESET;
        end
        else
        begin
            if (wr_control)
            begin
                interface_enable_q <= reg_wdata[imrc_pkg::BIT_ENABLE];
                reception_hold <= reg_wdata[imrc_pkg::BIT_RECEPTION_HOLD];
                rate_select <= reg_wdata[imrc_pkg::RATE_LSB +: imrc_pkg::RATE_W];
            end
            master_select <= next_master;
            transmit_select <= next_transmit;
            if (wr_own)
            begin
                own_address_register <= reg_wdata[7:1];
            end
            if (wr_mask)
            begin
                irq_mask <= reg_wdata[3:0];
            end
            irq_status <= next_irq_status;
        end
    end

    // The stall lasts until software clears the hold bit or turns to transmit,
    // so a hold left set cannot silently lose the following byte.
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            rx_stall <= 1'b0;
        end
        else if (ev_hold)
        begin
            rx_stall <= 1'b1;
        end
        else if (!reception_hold || transmit_select)
        begin
            rx_stall <= 1'b0;
        end
    end

    // Read path: data stand only in the cycle after the strobe.
    wire [7:0] control_view = {interface_enable_q, reception_hold, master_select,
        transmit_select, rate_select};
    wire [7:0] mode_view = {3'h0, rx_stall, frame_active, sync_format, mode_code};
    wire [7:0] read_mux = (reg_addr == imrc_pkg::OFF_CONTROL) ? control_view
        : (reg_addr == imrc_pkg::OFF_OWN_ADDR) ? {own_address_register, 1'b0}
        : (reg_addr == imrc_pkg::OFF_IRQ_STATUS) ? {4'h0, irq_status}
        : (reg_addr == imrc_pkg::OFF_IRQ_MASK) ? {4'h0, irq_mask}
        : (reg_addr == imrc_pkg::OFF_MODE_STATUS) ? mode_view
        : 8'h00;

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            rdata <= 8'h00;
        end
        else
        begin
            rdata <= reg_rd ? read_mux : 8'h00;
        end
    end

    // Divider runs only while enabled and master; the rate field reaches it always.
    assign rif.run = interface_enable_q && master_select;
    assign rif.frame_active = frame_active;
    assign rif.rate_code = rate_select;

    imrc_pkg::imrc_mode_e mode;
    assign mode = imrc_pkg::imrc_mode_e'({master_select, transmit_select});

    assign reg_rdata = rdata;
    assign irq = |(irq_status & irq_mask);
    assign mode_code = mode;
    assign next_rx_enable = !rx_stall;
    assign interface_enable = interface_enable_q;
    assign active_rate_code = rif.held_code;
    assign bit_tick = rif.half_tick;
    // Two-wire format pulls low only; synchronous format drives both levels.
    assign scl_out = sync_format ? rif.serial_clk : 1'b0;
    assign scl_oe = rif.run && (sync_format || !rif.serial_clk);

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    sequence s_master_event_arb;
        master_select && !sync_format && arb_lost;
    endsequence
    sequence s_in_slave_rx;
        !master_select && !transmit_select && (mode_code == 2'b00);
    endsequence

    property p_arb_drop;
        s_master_event_arb |=> s_in_slave_rx;
    endproperty
    a_arb_drop: assert property (p_arb_drop)
        else $error("Arbitration loss did not fall to slave receive.");

    property p_overrun_drop;
        master_select && sync_format && overrun |=> !master_select ##0 s_in_slave_rx;
    endproperty
    a_overrun_drop: assert property (p_overrun_drop)
        else $error("Overrun did not leave master mode.");

    property p_addr_match;
        s_in_slave_rx ##0 (first_byte_valid && first_byte[0]
            && (first_byte[7:1] == own_address_register))
            |=> transmit_select && (mode_code == 2'b01);
    endproperty
    a_addr_match: assert property (p_addr_match)
        else $error("Own address with read bit did not set transmit.");

    property p_hold_stops;
        receive_buffer_read && reception_hold && !transmit_select
            |=> !next_rx_enable && irq_status[imrc_pkg::EV_RX_HELD];
    endproperty
    a_hold_stops: assert property (p_hold_stops)
        else $error("Reception was not held after buffer read.");

    property p_hold_released;
        !reception_hold |=> next_rx_enable;
    endproperty
    a_hold_released: assert property (p_hold_released)
        else $error("Reception stayed held with the hold bit clear.");

    property p_mode_decode;
        wr_control && !drop_to_slave && !ev_match
            |=> mode_code == $past(reg_wdata[5:4]);
    endproperty
    a_mode_decode: assert property (p_mode_decode)
        else $error("Mode code does not follow written selection.");

    property p_sync_clock_out;
        interface_enable_q && sync_format && master_select |-> scl_oe;
    endproperty
    a_sync_clock_out: assert property (p_sync_clock_out)
        else $error("Serial clock not driven in synchronous master mode.");

    property p_slave_no_clock;
        !master_select |-> !scl_oe;
    endproperty
    a_slave_no_clock: assert property (p_slave_no_clock)
        else $error("Serial clock driven while slave.");

    // Read answers and sticky status; a set beats a clear in the same cycle.
    sequence s_control_read;
        reg_rd && (reg_addr == imrc_pkg::OFF_CONTROL);
    endsequence

    property p_read_idle;
        !reg_rd |=> (reg_rdata == 8'h00);
    endproperty
    a_read_idle: assert property (p_read_idle)
        else $error("Read data not zero outside the answer cycle.");

    property p_read_control;
        s_control_read |=> (reg_rdata == $past(control_view));
    endproperty
    a_read_control: assert property (p_read_control)
        else $error("Control register read back wrong.");

    property p_read_mode;
        reg_rd && (reg_addr == imrc_pkg::OFF_MODE_STATUS) |=> (reg_rdata == $past(mode_view));
    endproperty
    a_read_mode: assert property (p_read_mode)
        else $error("Mode status read back wrong.");

    property p_read_unmapped;
        reg_rd && (reg_addr > imrc_pkg::OFF_MODE_STATUS) |=> (reg_rdata == 8'h00);
    endproperty
    a_read_unmapped: assert property (p_read_unmapped)
        else $error("Unmapped address read not zero.");

    property p_event_sets;
        (events != 4'h0) |=> ((irq_status & $past(events)) == $past(events));
    endproperty
    a_event_sets: assert property (p_event_sets)
        else $error("Event did not set its status bit.");

    property p_status_sticky;
        !wr_status |=> ((irq_status & $past(irq_status)) == $past(irq_status));
    endproperty
    a_status_sticky: assert property (p_status_sticky)
        else $error("Status bit cleared without a write.");

    property p_status_clear;
        wr_status && (events == 4'h0)
            |=> (irq_status == ($past(irq_status) & ~$past(reg_wdata[3:0])));
    endproperty
    a_status_clear: assert property (p_status_clear)
        else $error("Status write one to clear wrong.");

    property p_arb_ignored_sync;
        arb_lost && sync_format && !overrun && !wr_control
            |=> (master_select == $past(master_select));
    endproperty
    a_arb_ignored_sync: assert property (p_arb_ignored_sync)
        else $error("Arbitration loss acted in synchronous format.");

    property p_match_needs_read;
        first_byte_valid && !first_byte[0] && !wr_control && !drop_to_slave
            |=> (transmit_select == $past(transmit_select));
    endproperty
    a_match_needs_read: assert property (p_match_needs_read)
        else $error("Transmit set without the read bit.");

    property p_mode_hold;
        !wr_control && !drop_to_slave && !ev_match |=> (mode_code == $past(mode_code));
    endproperty
    a_mode_hold: assert property (p_mode_hold)
        else $error("Mode changed with no write or event.");

    property p_stall_hold;
        rx_stall && reception_hold && !transmit_select |=> !next_rx_enable;
    endproperty
    a_stall_hold: assert property (p_stall_hold)
        else $error("Held reception resumed with the hold bit set.");

    property p_rate_follow;
        !frame_active |=> (active_rate_code == $past(rate_select));
    endproperty
    a_rate_follow: assert property (p_rate_follow)
        else $error("Divider did not take the rate code between frames.");
endmodule // imrc_mode_rate_ctrl

// file: verilog/imrc_pkg.sv
// Package of constants and types for the mode and rate control block.
package imrc_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam logic [2:0] OFF_CONTROL = 3'h0;
    localparam logic [2:0] OFF_OWN_ADDR = 3'h1;
    localparam logic [2:0] OFF_IRQ_STATUS = 3'h2;
    localparam logic [2:0] OFF_IRQ_MASK = 3'h3;
    localparam logic [2:0] OFF_MODE_STATUS = 3'h4;
    localparam int BIT_ENABLE = 7;
    localparam int BIT_RECEPTION_HOLD = 6;
    localparam int BIT_MASTER_SELECT = 5;
    localparam int BIT_TRANSMIT_SELECT = 4;
    localparam int RATE_LSB = 0;
    localparam int RATE_W = 4;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [6:0] OWN_ADDR_RESET = 7'h00;
    localparam logic [3:0] IRQ_RESET = 4'h0;
    localparam int EV_ARB_LOST = 0;
    localparam int EV_OVERRUN = 1;
    localparam int EV_ADDR_MATCH = 2;
    localparam int EV_RX_HELD = 3;
    localparam int EV_N = 4;
    typedef enum logic [1:0] {
        IMRC_SLAVE_RX = 2'b00,
        IMRC_SLAVE_TX = 2'b01,
        IMRC_MASTER_RX = 2'b10,
        IMRC_MASTER_TX = 2'b11
    } imrc_mode_e;
    // Divisor per rate code, index is the four-bit code.
    localparam logic [8:0] DIVISOR_TABLE [16] = '{
        9'd28, 9'd40, 9'd48, 9'd64, 9'd80, 9'd100, 9'd112, 9'd128,
        9'd56, 9'd80, 9'd96, 9'd128, 9'd160, 9'd200, 9'd224, 9'd256
    };
endpackage

// file: verilog/imrc_rate_div.sv
// Transfer clock divider producing the master serial clock.
`timescale 1ns/1ps
module imrc_rate_div #(
    parameter int CNT_W = 8
) (
    input wire logic core_clk,
    input wire logic reset,
    imrc_rate_if.div rif
);
    if (CNT_W < 8)
    begin : g_check
        $error("Divider counter too narrow for the largest divisor.");
    end

    logic [3:0] held_code;
    logic [CNT_W-1:0] count;
    logic serial_clk;
    logic [8:0] divisor;
    logic [CNT_W-1:0] half_last;
    logic at_half;
    logic code_load;

    // The code is only taken while no frame runs, so a mid-frame write cannot
    // stretch or shrink bits already on the wire.
    assign divisor = imrc_pkg::DIVISOR_TABLE[held_code];
    assign half_last = CNT_W'(divisor[8:1] - 8'h01);
    assign at_half = rif.run && (count == half_last);
    // A new code restarts the count, so a shorter divisor cannot leave the
    // counter above its end point and wrap through a long false half period.
    assign code_load = !rif.frame_active && (rif.rate_code != held_code);

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            held_code <= 4'h0;
            count <= '0;
            serial_clk <= 1'b1;
        end
        else
        begin
            if (!rif.frame_active)
            begin
                held_code <= rif.rate_code;
            end
            if (!rif.run)
            begin
                count <= '0;
                serial_clk <= 1'b1;
            end
            else if (at_half)
            begin
                count <= '0;
                serial_clk <= ~serial_clk;
            end
            else if (code_load)
            begin
                count <= '0;
            end
            else
            begin
                count <= count + 1'b1;
            end
        end
    end

    assign rif.serial_clk = serial_clk;
    assign rif.half_tick = at_half;
    assign rif.held_code = held_code;

    // Helper gap counter, read only by the assertions.
    logic [9:0] gap;
    always_ff @(posedge core_clk)
    begin
        if (reset || !rif.run || at_half || code_load)
        begin
            gap <= 10'h000;
        end
        else
        begin
            gap <= gap + 10'h001;
        end
    end

    property p_half_period;
        @(posedge core_clk) disable iff (reset)
        rif.run && $past(rif.run) && at_half && $stable(held_code)
            |-> (gap == 10'(divisor[8:1] - 9'd1));
    endproperty
    a_half_period: assert property (p_half_period)
        else $error("Serial clock half period does not match the divisor.");

    property p_divisor_hold;
        @(posedge core_clk) disable iff (reset)
        rif.frame_active && $past(rif.frame_active) |-> $stable(held_code);
    endproperty
    a_divisor_hold: assert property (p_divisor_hold)
        else $error("Divisor changed during a frame.");

    property p_idle_high;
        @(posedge core_clk) disable iff (reset)
        !rif.run |=> serial_clk;
    endproperty
    a_idle_high: assert property (p_idle_high)
        else $error("Serial clock toggled while not master.");
endmodule // imrc_rate_div

// file: verilog/imrc_rate_if.sv
// Interface joining the mode control to the transfer clock divider.
`timescale 1ns/1ps
interface imrc_rate_if;
    logic run;
    logic frame_active;
    logic [3:0] rate_code;
    logic serial_clk;
    logic half_tick;
    logic [3:0] held_code;
    modport ctrl (output run, output frame_active, output rate_code,
        input serial_clk, input half_tick, input held_code);
    modport div (input run, input frame_active, input rate_code,
        output serial_clk, output half_tick, output held_code);
endinterface
